/* File: ccw_map.svh */
// Purpose: Offsets, field positions, encodings and reset values of the counter unit
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register per word
// Notes:   Definitions only
`ifndef CCW_MAP_SVH
`define CCW_MAP_SVH

// ============================================================
// Register offsets
`define CCW_OFS_CTRL    8'h00
`define CCW_OFS_COUNT   8'h04
`define CCW_OFS_MATCH_A 8'h08
`define CCW_OFS_MATCH_B 8'h0c
`define CCW_OFS_FLAGS   8'h10
`define CCW_OFS_STATE   8'h14

// ============================================================
// Control word fields
`define CCW_F_MODE      2:0
`define CCW_B_ACT       4
`define CCW_B_FORCE     8
`define CCW_B_DIR       10
`define CCW_B_PORT      12

// ============================================================
// Wave mode encodings
`define CCW_MODE_NORMAL 3'h0
`define CCW_MODE_CLR_MATCH 3'h2
`define CCW_MODE_FPWM   3'h3
`define CCW_MODE_FPWM_A 3'h7

// ============================================================
// Output action encodings
`define CCW_ACT_NONE    2'h0
`define CCW_ACT_TOGGLE  2'h1
`define CCW_ACT_CLEAR   2'h2
`define CCW_ACT_SET     2'h3

// ============================================================
// Counter limits and reset values
`define CCW_CNT_MAX     8'hff
`define CCW_CNT_BOTTOM  8'h00
`define CCW_CNT_ONE     8'h01
`define CCW_RST_BYTE    8'h00
`define CCW_RST_MODE    3'h0
`define CCW_RESP_OKAY   1'b0
`define CCW_WORD_ZERO   32'h0000_0000

`endif

/* File: ccw_pkg.sv */
// Purpose: Types shared by the counter unit
// Assumes: ccw_map.svh holds all numeric constants
// Notes:   Types only
package ccw_pkg;

	typedef logic [7:0] ccw_byte_type;
	typedef logic [1:0] ccw_act_type;
	typedef logic [2:0] ccw_mode_type;

	// Bus data phase tracking
	typedef enum logic {
		CCW_BUS_IDLE,
		CCW_BUS_RDWAIT
	} ccw_bus_state_type;

endpackage : ccw_pkg

/* File: ccw_timer.sv */
// Purpose: Eight-bit counter, two match channels, waveform generator, AHB-Lite slave
// Assumes: timer_tick is a one-cycle enable in the hclk domain
// Notes:   Dual-slope modes, prescaler and asynchronous clocking not built
`timescale 1ns/1ps
`include "ccw_map.svh"

module ccw_timer (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic                 timer_tick,
	input  wire logic [2:0]           flag_ack,
	input  wire logic                 wave_in_a,
	input  wire logic                 wave_in_b,
	output logic                      wave_out_a,
	output logic                      wave_out_a_oe_n,
	output logic                      wave_out_b,
	output logic                      wave_out_b_oe_n
);
	import ccw_pkg::*;

	// ============================================================
	// Bus slave
	ccw_bus_state_type  bus_ff;
	logic               wr_pend_ff;
	ccw_byte_type       addr_ff;
	logic [31:0]        hrdata_ff;
	logic               acc_ok;
	logic               wr_ctrl;
	logic               wr_count;
	logic               wr_flags;
	logic [1:0]         wr_match;
	logic [31:0]        rd_mux;

	// Size is not checked: only whole-word transfers are expected
	assign acc_ok = hsel & hready & htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_ff     <= CCW_BUS_IDLE;
			wr_pend_ff <= 1'b0;
			addr_ff    <= `CCW_RST_BYTE;
		end else begin
			wr_pend_ff <= acc_ok & hwrite;
			bus_ff     <= (acc_ok & ~hwrite) ? CCW_BUS_RDWAIT : CCW_BUS_IDLE;
			if (acc_ok) begin
				addr_ff <= haddr[7:0];
			end
		end
	end

	assign wr_ctrl     = wr_pend_ff & (addr_ff == `CCW_OFS_CTRL);
	assign wr_count    = wr_pend_ff & (addr_ff == `CCW_OFS_COUNT);
	assign wr_flags    = wr_pend_ff & (addr_ff == `CCW_OFS_FLAGS);
	assign wr_match[0] = wr_pend_ff & (addr_ff == `CCW_OFS_MATCH_A);
	assign wr_match[1] = wr_pend_ff & (addr_ff == `CCW_OFS_MATCH_B);

	// One wait state on reads so a write just before is already visible
	assign hreadyout = (bus_ff != CCW_BUS_RDWAIT);
	assign hresp     = `CCW_RESP_OKAY;
	assign hrdata    = hrdata_ff;

	// ============================================================
	// Control word
	ccw_mode_type             mode_ff;
	logic [1:0][1:0]          act_ff;
	logic [1:0]               dir_ff;
	logic [1:0]               port_ff;
	logic [1:0]               force_req;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ff <= `CCW_RST_MODE;
			act_ff  <= '0;
			dir_ff  <= '0;
			port_ff <= '0;
		end else if (wr_ctrl) begin
			// Action field is live at once, no buffering
			mode_ff   <= hwdata[`CCW_F_MODE];
			act_ff[0] <= hwdata[`CCW_B_ACT +: 2];
			act_ff[1] <= hwdata[`CCW_B_ACT + 2 +: 2];
			dir_ff    <= hwdata[`CCW_B_DIR +: 2];
			port_ff   <= hwdata[`CCW_B_PORT +: 2];
		end
	end

	assign force_req = {2{wr_ctrl}} & hwdata[`CCW_B_FORCE +: 2];

	// ============================================================
	// Counter
	ccw_byte_type       cnt_ff;
	ccw_byte_type       cnt_next;
	ccw_byte_type       top;
	logic               block_ff;
	logic               wrap_flag_ff;
	logic               pwm;
	logic               clr_mode;
	logic               at_top;
	logic               wrap_ev;
	logic               bottom_ev;
	logic [1:0][7:0]    mval;
	logic [1:0]         match_ev;
	logic [1:0]         match_flag;
	logic [1:0]         out_state;

	assign pwm    = (mode_ff == `CCW_MODE_FPWM) | (mode_ff == `CCW_MODE_FPWM_A);
	assign clr_mode = (mode_ff == `CCW_MODE_CLR_MATCH);
	assign top    = (mode_ff == `CCW_MODE_FPWM_A) ? mval[0] : `CCW_CNT_MAX;
	assign at_top = (cnt_ff == top);

	always_comb begin
		if (pwm) begin
			cnt_next = at_top ? `CCW_CNT_BOTTOM : cnt_ff + `CCW_CNT_ONE;
		end else if (clr_mode) begin
			// Low match value is missed and the count runs through MAX
			cnt_next = (cnt_ff == mval[0]) ? `CCW_CNT_BOTTOM : cnt_ff + `CCW_CNT_ONE;
		end else begin
			cnt_next = cnt_ff + `CCW_CNT_ONE;
		end
	end

	// Overflow as the counter wraps from MAX to zero, or on reaching top in fast PWM
	assign wrap_ev   = timer_tick & (pwm ? (cnt_next == top) : (cnt_ff == `CCW_CNT_MAX));
	assign bottom_ev = timer_tick & pwm & at_top;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= `CCW_RST_BYTE;
		end else if (wr_count) begin
			cnt_ff <= hwdata[7:0];
		end else if (timer_tick) begin
			cnt_ff <= cnt_next;
		end
	end

	// Blocking survives until one tick has passed, even with no tick source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			block_ff <= 1'b0;
		end else if (wr_count) begin
			block_ff <= 1'b1;
		end else if (timer_tick) begin
			block_ff <= 1'b0;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wrap_flag_ff <= 1'b0;
		end else if (wrap_ev) begin
			wrap_flag_ff <= 1'b1;
		end else if ((wr_flags & hwdata[0]) | flag_ack[0]) begin
			wrap_flag_ff <= 1'b0;
		end
	end

	// ============================================================
	// Match channels
	function automatic logic ccw_apply(input logic st, input ccw_act_type act);
		case (act)
			`CCW_ACT_TOGGLE: ccw_apply = ~st;
			`CCW_ACT_CLEAR:  ccw_apply = 1'b0;
			`CCW_ACT_SET:    ccw_apply = 1'b1;
			default:         ccw_apply = st;
		endcase
	endfunction : ccw_apply

	logic [1:0] pin_val;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			ccw_byte_type buf_ff;
			ccw_byte_type act_val_ff;
			logic         st_ff;
			logic         flag_ff;
			logic         pin_ff;
			logic         nxt_st;

			assign mval[gi]       = act_val_ff;
			assign match_ev[gi]   = timer_tick & ~block_ff & (cnt_ff == act_val_ff);
			assign match_flag[gi] = flag_ff;
			assign out_state[gi]  = st_ff;
			assign pin_val[gi]    = pin_ff;

			// Buffer is what software reads back in every mode
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					buf_ff <= `CCW_RST_BYTE;
				end else if (wr_match[gi]) begin
					buf_ff <= hwdata[7:0];
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					act_val_ff <= `CCW_RST_BYTE;
				end else if (wr_match[gi] & ~pwm) begin
					act_val_ff <= hwdata[7:0];
				end else if (bottom_ev) begin
					act_val_ff <= buf_ff;
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flag_ff <= 1'b0;
				end else if (match_ev[gi]) begin
					flag_ff <= 1'b1;
				end else if ((wr_flags & hwdata[1 + gi]) | flag_ack[1 + gi]) begin
					flag_ff <= 1'b0;
				end
			end

			// Bottom beats match so a MAX value gives a steady level
			always_comb begin
				nxt_st = st_ff;
				if (force_req[gi] & ~pwm) begin
					// Force takes the action written in the same word
					nxt_st = ccw_apply(st_ff, hwdata[`CCW_B_ACT + 2 * gi +: 2]);
				end else if (bottom_ev & act_ff[gi][1]) begin
					nxt_st = ~act_ff[gi][0];
				end else if (match_ev[gi]) begin
					nxt_st = ccw_apply(st_ff, act_ff[gi]);
				end
			end

			// Mode writes touch the output state only through the force bits, outside fast PWM
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					st_ff <= 1'b0;
				end else begin
					st_ff <= nxt_st;
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_ff <= 1'b0;
				end else begin
					pin_ff <= (|act_ff[gi]) ? st_ff : port_ff[gi];
				end
			end
		end
	endgenerate

	assign wave_out_a      = pin_val[0];
	assign wave_out_b      = pin_val[1];
	assign wave_out_a_oe_n = ~dir_ff[0];
	assign wave_out_b_oe_n = ~dir_ff[1];

	// ============================================================
	// Read data, loaded in the wait cycle
	always_comb begin
		rd_mux = `CCW_WORD_ZERO;
		case (addr_ff)
			`CCW_OFS_CTRL: begin
				rd_mux[`CCW_F_MODE]         = mode_ff;
				rd_mux[`CCW_B_ACT +: 2]     = act_ff[0];
				rd_mux[`CCW_B_ACT + 2 +: 2] = act_ff[1];
				rd_mux[`CCW_B_DIR +: 2]     = dir_ff;
				rd_mux[`CCW_B_PORT +: 2]    = port_ff;
			end
			`CCW_OFS_COUNT:   rd_mux[7:0] = cnt_ff;
			`CCW_OFS_MATCH_A: rd_mux[7:0] = g_ch[0].buf_ff;
			`CCW_OFS_MATCH_B: rd_mux[7:0] = g_ch[1].buf_ff;
			`CCW_OFS_FLAGS:   rd_mux[2:0] = {match_flag, wrap_flag_ff};
			`CCW_OFS_STATE:   rd_mux[3:0] = {wave_in_b, wave_in_a, out_state};
			default:          rd_mux = `CCW_WORD_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= `CCW_WORD_ZERO;
		end else if (bus_ff == CCW_BUS_RDWAIT) begin
			hrdata_ff <= rd_mux;
		end
	end

	// ============================================================
	// Checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_cnt_write_wins: assert property (wr_count |=> cnt_ff == $past(hwdata[7:0]))
		else $error("counter write lost");

	a_block_after_write: assert property ((wr_count ##1 (timer_tick & ~wr_count)) |=> !$rose(match_flag[0]) && !$rose(match_flag[1]))
		else $error("match not blocked after counter write");

	a_mode_keeps_state: assert property ((wr_ctrl && hwdata[`CCW_B_FORCE +: 2] == 2'h0 && !timer_tick) |=> $stable(out_state))
		else $error("output state moved on mode write");

	a_zero_action_hold: assert property ((act_ff[0] == `CCW_ACT_NONE && !force_req[0])
		|=> out_state[0] == $past(out_state[0]))
		else $error("output state changed with action zero");

	a_normal_wrap: assert property ((timer_tick && mode_ff == `CCW_MODE_NORMAL && cnt_ff == `CCW_CNT_MAX && !wr_count) |=> (cnt_ff == `CCW_CNT_BOTTOM && wrap_flag_ff))
		else $error("normal mode wrap wrong");

	a_match_clear: assert property ((timer_tick && clr_mode && cnt_ff == mval[0] && !wr_count)
		|=> cnt_ff == `CCW_CNT_BOTTOM
		##1 (cnt_ff == `CCW_CNT_BOTTOM || $past(wr_count) || $past(timer_tick)))
		else $error("clear on match failed");

	a_pwm_top_clear: assert property ((timer_tick && pwm && at_top && !wr_count) |=> cnt_ff == `CCW_CNT_BOTTOM)
		else $error("fast PWM did not clear after top");

	a_pwm_wrap_flag: assert property ((timer_tick && pwm && cnt_next == top && !wr_count) |=> wrap_flag_ff)
		else $error("fast PWM wrap flag missing");

	a_buffer_hold: assert property ((pwm && wr_match[0] && !bottom_ev) |=> mval[0] == $past(mval[0]))
		else $error("active match value changed outside bottom");

	a_force_no_flag: assert property ((|force_req && !pwm && match_ev == 2'b00) |=> !$rose(match_flag[0]) && !$rose(match_flag[1]))
		else $error("forced match set a flag");

	a_flag_set: assert property (match_ev[0] |=> match_flag[0])
		else $error("match flag not set");

	a_pin_source: assert property ((|act_ff[0]) |=> wave_out_a == $past(out_state[0]))
		else $error("pin not driven from output state");

	a_toggle_match: assert property ((match_ev[0] && act_ff[0] == `CCW_ACT_TOGGLE && !force_req[0] && !bottom_ev) |=> out_state[0] != $past(out_state[0]))
		else $error("toggle on match missing");

	a_fpwm_bottom_set: assert property ((bottom_ev && act_ff[0] == `CCW_ACT_CLEAR) |=> out_state[0])
		else $error("non-inverted output not set at bottom");

endmodule : ccw_timer

/* File: ccw_cpu_model.sv */
// Purpose: Processor-core stand-in driving the AHB-Lite register bus of the counter unit
// Assumes: One slave, so hready is that slave's hreadyout
// Notes:   The task starts and ends just after a rising edge
`timescale 1ns/1ps

module ccw_cpu_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);

	// ============================================================
	// Idle bus
	initial begin
		hsel = 1'b1;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'hffff_ffff;
	end

	// ============================================================
	// Single word transfer; only up-counting modes are used, so bottom is never written downcounting
	task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr_en;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		q = hrdata;
		// Released data bus shows the inverse, so stale data never looks valid
		hwdata <= ~d;
	endtask : bus

endmodule : ccw_cpu_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the counter unit through register accesses
// Assumes: One-cycle timer ticks, every other hclk cycle
// Notes:   Pin values are sampled at the falling edge
`timescale 1ns/1ps
`include "ccw_map.svh"

module testbench;
	logic        hclk, hresetn, hsel, hwrite, hready, hresp, timer_tick;
	logic        wave_in_a, wave_in_b, wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, flag_ack;
	int          num_errors;
	int          checks;

	ccw_cpu_model u_ccw_cpu_model (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	ccw_timer u_ccw_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .timer_tick(timer_tick), .flag_ack(flag_ack),
		.wave_in_a(wave_in_a), .wave_in_b(wave_in_b), .wave_out_a(wave_out_a),
		.wave_out_a_oe_n(wave_out_a_oe_n), .wave_out_b(wave_out_b), .wave_out_b_oe_n(wave_out_b_oe_n));

	// ============================================================
	// Clock, reset, watchdog
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end

	// ============================================================
	// Helpers
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] q);
		checks++;
		if (q !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, q);
			num_errors++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_ccw_cpu_model.bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_ccw_cpu_model.bus(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask : rdc

	task automatic pins(input logic [3:0] e);
		// Pin value is registered one edge after the control write
		@(posedge hclk);
		@(negedge hclk);
		chk("pins", {28'h0, e}, {28'h0, wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n});
		@(posedge hclk);
	endtask : pins

	task automatic tick(input int n);
		repeat (n) begin
			timer_tick <= 1'b1;
			@(posedge hclk);
			timer_tick <= 1'b0;
			@(posedge hclk);
		end
	endtask : tick

	// Control word: hi = {port B, port A, dir B, dir A, force B, force A}
	function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] aa, input logic [1:0] ab,
		input logic [5:0] hi);
		return {18'h0, hi, ab, aa, 1'b0, m};
	endfunction : cw

	logic [1:0] acts [5] = '{`CCW_ACT_SET, `CCW_ACT_NONE, `CCW_ACT_TOGGLE, `CCW_ACT_CLEAR, `CCW_ACT_SET};
	logic [3:0] sexp [5] = '{4'h9, 4'h9, 4'h8, 4'h8, 4'h9};

	// ============================================================
	// Main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		hresetn = 1'b0;
		timer_tick = 1'b0;
		flag_ack = 3'h0;
		wave_in_a = 1'b0;
		wave_in_b = 1'b1;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(`CCW_OFS_CTRL, 32'h0);
		rdc(`CCW_OFS_MATCH_A, 32'h0);
		rdc(`CCW_OFS_FLAGS, 32'h0);
		rdc(`CCW_OFS_STATE, 32'h8);
		rdc(8'h18, 32'h0);
		wr(`CCW_OFS_COUNT, 32'h05);
		repeat (6) @(posedge hclk);
		rdc(`CCW_OFS_COUNT, 32'h05);
		wr(`CCW_OFS_COUNT, 32'hfe);
		tick(1);
		rdc(`CCW_OFS_FLAGS, 32'h0);
		tick(1);
		rdc(`CCW_OFS_COUNT, 32'h00);
		rdc(`CCW_OFS_FLAGS, 32'h1);
		wr(`CCW_OFS_FLAGS, 32'h1);
		rdc(`CCW_OFS_FLAGS, 32'h0);
		// Match on a just-written count is suppressed for one tick
		wr(`CCW_OFS_MATCH_A, 32'h10);
		wr(`CCW_OFS_COUNT, 32'h10);
		tick(1);
		rdc(`CCW_OFS_FLAGS, 32'h0);
		wr(`CCW_OFS_COUNT, 32'h0f);
		tick(2);
		rdc(`CCW_OFS_FLAGS, 32'h2);
		flag_ack <= 3'h2;
		tick(1);
		flag_ack <= 3'h0;
		rdc(`CCW_OFS_FLAGS, 32'h0);
		// Output state preset by force before the pin is enabled
		for (int i = 0; i < 5; i++) begin
			wr(`CCW_OFS_CTRL, cw(`CCW_MODE_NORMAL, acts[i], `CCW_ACT_NONE, 6'h01));
			rdc(`CCW_OFS_STATE, {28'h0, sexp[i]});
		end
		rdc(`CCW_OFS_COUNT, 32'h12);
		rdc(`CCW_OFS_FLAGS, 32'h0);
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_NORMAL, `CCW_ACT_SET, `CCW_ACT_NONE, 6'h04));
		pins(4'b1001);
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_NORMAL, `CCW_ACT_NONE, `CCW_ACT_NONE, 6'h04));
		pins(4'b0001);
		// Clear on match with toggle
		wr(`CCW_OFS_MATCH_A, 32'h03);
		wr(`CCW_OFS_COUNT, 32'h00);
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_CLR_MATCH, `CCW_ACT_TOGGLE, `CCW_ACT_NONE, 6'h04));
		rdc(`CCW_OFS_STATE, 32'h9);
		tick(3);
		rdc(`CCW_OFS_COUNT, 32'h03);
		tick(1);
		rdc(`CCW_OFS_COUNT, 32'h00);
		rdc(`CCW_OFS_STATE, 32'h8);
		pins(4'b0001);
		wr(`CCW_OFS_COUNT, 32'h10);
		wr(`CCW_OFS_MATCH_A, 32'h02);
		wr(`CCW_OFS_FLAGS, 32'h7);
		tick(8'hf0);
		rdc(`CCW_OFS_COUNT, 32'h00);
		rdc(`CCW_OFS_FLAGS, 32'h1);
		tick(3);
		rdc(`CCW_OFS_COUNT, 32'h00);
		rdc(`CCW_OFS_STATE, 32'h9);
		// Fast PWM, A non-inverting, B inverting
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_NORMAL, `CCW_ACT_NONE, `CCW_ACT_NONE, 6'h04));
		wr(`CCW_OFS_MATCH_B, 32'h03);
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_FPWM, `CCW_ACT_CLEAR, `CCW_ACT_SET, 6'h04));
		wr(`CCW_OFS_MATCH_A, 32'h05);
		rdc(`CCW_OFS_MATCH_A, 32'h05);
		wr(`CCW_OFS_COUNT, 32'h00);
		wr(`CCW_OFS_FLAGS, 32'h7);
		tick(3);
		rdc(`CCW_OFS_STATE, 32'h8);
		tick(1);
		rdc(`CCW_OFS_STATE, 32'ha);
		tick(8'hfb);
		rdc(`CCW_OFS_COUNT, 32'hff);
		rdc(`CCW_OFS_FLAGS, 32'h7);
		tick(1);
		rdc(`CCW_OFS_COUNT, 32'h00);
		rdc(`CCW_OFS_STATE, 32'h9);
		wr(`CCW_OFS_FLAGS, 32'h7);
		tick(3);
		rdc(`CCW_OFS_STATE, 32'h9);
		tick(3);
		rdc(`CCW_OFS_STATE, 32'ha);
		// Top from channel A
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_FPWM_A, `CCW_ACT_NONE, `CCW_ACT_NONE, 6'h04));
		wr(`CCW_OFS_COUNT, 32'h00);
		tick(5);
		rdc(`CCW_OFS_COUNT, 32'h05);
		tick(1);
		rdc(`CCW_OFS_COUNT, 32'h00);
		// Toggle at top gives half duty
		wr(`CCW_OFS_CTRL, cw(`CCW_MODE_FPWM_A, `CCW_ACT_TOGGLE, `CCW_ACT_NONE, 6'h04));
		tick(6);
		rdc(`CCW_OFS_STATE, 32'hb);
		tick(6);
		rdc(`CCW_OFS_STATE, 32'ha);
		wrap_up();
	end

endmodule : testbench
